/* rtl/mft_ctrl_defs.vh */
/*
  Register offsets, field positions, reset values and codes of the
  multifunction timer control block.
  Assumes an 8-bit register port; included by its bare name.
*/
`ifndef MFT_CTRL_DEFS_VH
`define MFT_CTRL_DEFS_VH

// ==========================================================
// register offsets
`define OFS_TIMER_CONTROL 8'hF8
`define OFS_TIMER_MODE 8'hF9
`define OFS_INPUT_PIN_CONTROL 8'hFA
`define OFS_PRESCALER_PRESET 8'hFB
`define OFS_FIRST_OUTPUT_CONTROL 8'hFC

// ==========================================================
// reset values
`define RST_REG8 8'h00
`define RST_COUNT 16'h0000

// ==========================================================
// timer_control fields
`define B_RUN_ENABLE 7
`define B_CLR_CAPTURE 6
`define B_CLR_COMPARE 5
`define B_CLR_STROBE 4
`define B_DIR_SW 3
`define B_DIR_STATUS 2
`define B_WRAP_CAPT 1
`define B_RUNNING 0

// ==========================================================
// timer_mode fields
`define B_OUT1_EN 7
`define B_OUT0_EN 6
`define B_BIVALUE 5
`define B_REG1_MODE 4
`define B_REG0_MODE 3
`define B_PARALLEL 2
`define B_RETRIG_OFF 1
`define B_ONE_SHOT 0

// ==========================================================
// input_pin_control and first_output_control fields
`define F_IN_FUNC 7:4
`define F_EDGE_A 3:2
`define F_EDGE_B 1:0
`define F_ACT_CMP0 7:6
`define F_ACT_CMP1 5:4
`define F_ACT_WRAP 3:2
`define B_CMP_EVENT_EN 1
`define B_OUT_PRESET 0

// ==========================================================
// pin roles
`define ROLE_NONE 4'h0
`define ROLE_TRIG 4'h1
`define ROLE_GATE 4'h2
`define ROLE_CLK 4'h3
`define ROLE_CLK_UP 4'h4
`define ROLE_CLK_DN 4'h5
`define ROLE_UPDN 4'h6
`define ROLE_TRIG_UP 4'h7
`define ROLE_TRIG_DN 4'h8
`define ROLE_AUTO 4'h9

// ==========================================================
// output actions
`define ACT_SET 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_RESET 2'h2
`define ACT_NOP 2'h3

`endif

/* rtl/multifunction_timer_control.v */
/*
  Control, mode, input-pin, prescaler and first-output logic of a 16-bit
  up/down multifunction timer, with its register file on a plain port.
  Assumes pins arrive asynchronously; compare and load values come from
  same-clock logic outside; read data stand one cycle after the strobe.
*/
`timescale 1ns/1ps
`include "mft_ctrl_defs.vh"

module multifunction_timer_control (
  input wire clock_in,
  input wire sys_rst_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  input wire global_count_enable_in,
  input wire first_input_pin_in,
  input wire second_input_pin_in,
  input wire [15:0] load_value_0_in,
  input wire [15:0] load_value_1_in,
  input wire [15:0] compare_value_0_in,
  input wire [15:0] compare_value_1_in,
  output reg [15:0] count_out,
  output reg [15:0] capture_0_out,
  output reg [15:0] capture_1_out,
  output reg first_output_pin_out,
  output reg second_output_pin_out,
  output reg compare_event_out,
  output reg parallel_mode_out
);

  // ==========================================================
  // helpers
  // pin roles
  function [7:0] pin_roles;
    input [3:0] f;
    begin
      case (f)
        4'h0: pin_roles = {`ROLE_NONE, `ROLE_NONE};
        4'h1: pin_roles = {`ROLE_NONE, `ROLE_TRIG};
        4'h2: pin_roles = {`ROLE_GATE, `ROLE_NONE};
        4'h3: pin_roles = {`ROLE_GATE, `ROLE_TRIG};
        4'h4: pin_roles = {`ROLE_NONE, `ROLE_CLK};
        4'h5: pin_roles = {`ROLE_TRIG, `ROLE_NONE};
        4'h6: pin_roles = {`ROLE_GATE, `ROLE_CLK};
        4'h7: pin_roles = {`ROLE_TRIG, `ROLE_TRIG};
        4'h8: pin_roles = {`ROLE_CLK_UP, `ROLE_CLK_DN};
        4'h9: pin_roles = {`ROLE_UPDN, `ROLE_CLK};
        4'hA: pin_roles = {`ROLE_TRIG_UP, `ROLE_TRIG_DN};
        4'hB: pin_roles = {`ROLE_UPDN, `ROLE_NONE};
        4'hC: pin_roles = {`ROLE_AUTO, `ROLE_AUTO};
        4'hD: pin_roles = {`ROLE_TRIG, `ROLE_CLK};
        4'hE: pin_roles = {`ROLE_CLK, `ROLE_TRIG};
        default: pin_roles = {`ROLE_TRIG, `ROLE_GATE};
      endcase
    end
  endfunction

  function edge_hit;
    input [1:0] sel;
    input prev;
    input cur;
    begin
      edge_hit = (sel[1] & cur & ~prev) | (sel[0] & ~cur & prev);
    end
  endfunction

  function is_trig;
    input [3:0] r;
    begin
      is_trig = (r == `ROLE_TRIG) | (r == `ROLE_TRIG_UP) | (r == `ROLE_TRIG_DN);
    end
  endfunction

  function is_clk;
    input [3:0] r;
    begin
      is_clk = (r == `ROLE_CLK) | (r == `ROLE_CLK_UP) | (r == `ROLE_CLK_DN) |
               (r == `ROLE_AUTO);
    end
  endfunction

  function apply_act;
    input [1:0] act;
    input lvl;
    begin
      case (act)
        `ACT_SET: apply_act = 1'b1;
        `ACT_TOGGLE: apply_act = ~lvl;
        `ACT_RESET: apply_act = 1'b0;
        default: apply_act = lvl;
      endcase
    end
  endfunction

  // ==========================================================
  // registers
  reg [7:0] ctrl_q;
  reg [7:0] mode_q;
  reg [7:0] inctl_q;
  reg [7:0] preset_q;
  reg [7:0] outctl_q;
  reg clr_strobe_q;
  reg [7:0] presc_q;
  reg [15:0] count_q;
  reg hw_dir_q;
  reg dir_status_q;
  reg running_q;
  reg halt_q;
  reg wrap_seen_q;
  reg wrap_capt_q;
  reg biload_sel_q;
  reg a_s1_q, a_s2_q, a_p_q;
  reg b_s1_q, b_s2_q, b_p_q;

  // ==========================================================
  // input pins: two flops, then edge history
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      {a_s1_q, a_s2_q, a_p_q} <= 3'b000;
      {b_s1_q, b_s2_q, b_p_q} <= 3'b000;
    end else begin
      {a_s1_q, a_s2_q, a_p_q} <= {first_input_pin_in, a_s1_q, a_s2_q};
      {b_s1_q, b_s2_q, b_p_q} <= {second_input_pin_in, b_s1_q, b_s2_q};
    end
  end

  // ==========================================================
  // decode
  wire [7:0] roles = pin_roles(inctl_q[`F_IN_FUNC]);
  wire [3:0] role_a = roles[7:4];
  wire [3:0] role_b = roles[3:0];
  wire edge_a = edge_hit(inctl_q[`F_EDGE_A], a_p_q, a_s2_q);
  wire edge_b = edge_hit(inctl_q[`F_EDGE_B], b_p_q, b_s2_q);
  wire trig_a = edge_a & is_trig(role_a);
  wire trig_b = edge_b & is_trig(role_b);
  wire trig_any = trig_a | trig_b;
  wire gate_ok = ~((role_a == `ROLE_GATE) & ~a_s2_q) & ~((role_b == `ROLE_GATE) & ~b_s2_q);
  wire ext_clk = is_clk(role_a) | is_clk(role_b);
  wire src_tick = ext_clk ? ((edge_a & is_clk(role_a)) | (edge_b & is_clk(role_b))) : 1'b1;
  wire dir_fixed = (role_a == `ROLE_UPDN) | (role_a == `ROLE_CLK_UP) |
                   (role_a == `ROLE_TRIG_UP) | (role_a == `ROLE_AUTO);

  wire dir_up = dir_fixed ? hw_dir_q : ctrl_q[`B_DIR_SW];

  // mode decode; register1 mode unused in bivalue
  wire bivalue = mode_q[`B_BIVALUE];
  wire cap0_mode = mode_q[`B_REG0_MODE];
  wire cap1_mode = ~bivalue & mode_q[`B_REG1_MODE];
  wire biload = bivalue & ~cap0_mode;
  wire bicapture = bivalue & cap0_mode;

  wire run_ok = ctrl_q[`B_RUN_ENABLE] & global_count_enable_in & gate_ok & ~halt_q;
  wire presc_tick = run_ok & src_tick;
  wire cnt_tick = presc_tick & (presc_q == 8'h00);
  wire wrap = cnt_tick & (dir_up ? (count_q == 16'hFFFF) : (count_q == 16'h0000));
  wire [15:0] count_step = dir_up ? count_q + 16'h0001 : count_q - 16'h0001;
  wire cmp0_hit = cnt_tick & (count_step == compare_value_0_in);
  wire cmp1_hit = cnt_tick & (count_step == compare_value_1_in);

  // triggers act while stopped; retrigger gate
  wire retrig_block = mode_q[`B_RETRIG_OFF] & running_q;
  wire do_cap0 = trig_any & (bicapture ? trig_a : cap0_mode & ~bivalue);
  wire do_cap1 = trig_any & (bicapture ? trig_b : cap1_mode);
  wire do_load = trig_any & ~bicapture & ~cap0_mode & ~retrig_block;
  wire [15:0] load_val = (biload & biload_sel_q) ? load_value_1_in : load_value_0_in;

  wire clr_cnt = clr_strobe_q | (ctrl_q[`B_CLR_CAPTURE] & (do_cap0 | do_cap1)) |
                 (ctrl_q[`B_CLR_COMPARE] & cmp0_hit);

  // ==========================================================
  // register port
  // writes land on next edge
  wire wr_ctrl = reg_wr_in & (reg_addr_in == `OFS_TIMER_CONTROL);
  wire wr_out = reg_wr_in & (reg_addr_in == `OFS_FIRST_OUTPUT_CONTROL);

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      {ctrl_q, mode_q, inctl_q, preset_q, outctl_q} <= {5{`RST_REG8}};
      clr_strobe_q <= 1'b0;
      reg_rdata_out <= `RST_REG8;
    end else begin
      clr_strobe_q <= wr_ctrl & reg_wdata_in[`B_CLR_STROBE];
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_in & 8'hE8;
      end
      if (reg_wr_in & (reg_addr_in == `OFS_TIMER_MODE)) begin
        mode_q <= reg_wdata_in;
      end
      if (reg_wr_in & (reg_addr_in == `OFS_INPUT_PIN_CONTROL)) begin
        inctl_q <= reg_wdata_in;
      end
      if (reg_wr_in & (reg_addr_in == `OFS_PRESCALER_PRESET)) begin
        preset_q <= reg_wdata_in;
      end
      if (wr_out) begin
        outctl_q <= {reg_wdata_in[7:1], 1'b0};
      end
      reg_rdata_out <= `RST_REG8;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `OFS_TIMER_CONTROL:
            reg_rdata_out <= {ctrl_q[7:5], 1'b0, ctrl_q[`B_DIR_SW], dir_status_q,
                              wrap_capt_q, running_q};
          `OFS_TIMER_MODE: reg_rdata_out <= mode_q;
          `OFS_INPUT_PIN_CONTROL: reg_rdata_out <= inctl_q;
          `OFS_PRESCALER_PRESET: reg_rdata_out <= preset_q;
          `OFS_FIRST_OUTPUT_CONTROL: reg_rdata_out <= {outctl_q[7:1], first_output_pin_out};
          default: reg_rdata_out <= `RST_REG8;
        endcase
      end
    end
  end

  // ==========================================================
  // counter, prescaler, captures
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      presc_q <= 8'h00;
      {count_q, count_out} <= {2{`RST_COUNT}};
      {capture_0_out, capture_1_out} <= {2{`RST_COUNT}};
      hw_dir_q <= 1'b1;
      {dir_status_q, running_q, halt_q} <= 3'b000;
      {wrap_seen_q, wrap_capt_q, biload_sel_q} <= 3'b000;
    end else begin
      if (role_a == `ROLE_UPDN) begin
        hw_dir_q <= a_s2_q;
      end else if ((role_a == `ROLE_CLK_UP) | (role_a == `ROLE_TRIG_UP)) begin
        if (edge_a) begin
          hw_dir_q <= 1'b1;
        end else if (edge_b) begin
          hw_dir_q <= 1'b0;
        end
      end else if ((role_a == `ROLE_AUTO) & edge_a) begin
        // quadrature: B level at A edge picks direction
        hw_dir_q <= a_s2_q ^ b_s2_q;
      end
      dir_status_q <= dir_up;
      running_q <= run_ok;
      // one-shot halts at end of count
      if (do_load | (trig_any & ~mode_q[`B_ONE_SHOT])) begin
        halt_q <= 1'b0;
      end else if (wrap & mode_q[`B_ONE_SHOT]) begin
        halt_q <= 1'b1;
      end
      if (do_cap0) begin
        capture_0_out <= count_q;
      end
      if (do_cap1) begin
        capture_1_out <= count_q;
      end
      // wrap flag sampled at capture 0
      if (do_cap0) begin
        wrap_capt_q <= wrap_seen_q | wrap;
        wrap_seen_q <= 1'b0;
      end else if (wrap) begin
        wrap_seen_q <= 1'b1;
      end
      if (do_load & biload) begin
        biload_sel_q <= ~biload_sel_q;
      end
      // preset enters on clear, load or prescaler expiry
      if (clr_cnt) begin
        count_q <= `RST_COUNT;
        presc_q <= preset_q;
      end else if (do_load) begin
        count_q <= load_val;
        presc_q <= preset_q;
      end else if (presc_tick) begin
        if (presc_q == 8'h00) begin
          presc_q <= preset_q;
          if (wrap & ~cap0_mode) begin
            count_q <= load_val;
          end else begin
            count_q <= count_step;
          end
        end else begin
          presc_q <= presc_q - 8'h01;
        end
      end
      count_out <= count_q;
    end
  end

  // ==========================================================
  // output pins and on-chip event
  reg out_lvl_q;
  reg [1:0] act_c;
  always @* begin
    act_c = `ACT_NOP;
    if (cmp0_hit) begin
      act_c = act_c & outctl_q[`F_ACT_CMP0];
    end
    if (cmp1_hit) begin
      act_c = act_c & outctl_q[`F_ACT_CMP1];
    end
    if (wrap) begin
      act_c = act_c & outctl_q[`F_ACT_WRAP];
    end
  end

  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      {out_lvl_q, compare_event_out, parallel_mode_out} <= 3'b000;
      {first_output_pin_out, second_output_pin_out} <= 2'b11;
    end else begin
      if (wr_out) begin
        out_lvl_q <= reg_wdata_in[`B_OUT_PRESET];
      end else begin
        out_lvl_q <= apply_act(act_c, out_lvl_q);
      end
      first_output_pin_out <= mode_q[`B_OUT0_EN] ? out_lvl_q : 1'b1;
      second_output_pin_out <= 1'b1;
      compare_event_out <= cmp0_hit & outctl_q[`B_CMP_EVENT_EN];
      parallel_mode_out <= mode_q[`B_PARALLEL];
    end
  end

endmodule // multifunction_timer_control

/* bench/timer_ctrl_sva.sv */
/*
  Port checker of the timer control block.
  Assumes one clock, synchronous reset; attached by the bind at the foot.
*/
`timescale 1ns/1ps
module timer_ctrl_sva (
  input wire clock_in,
  input wire sys_rst_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire [15:0] count_out,
  input wire first_output_pin_out,
  input wire second_output_pin_out,
  input wire compare_event_out,
  input wire parallel_mode_out
);
  reg [7:0] ctl_q;
  reg [7:0] mode_q;
  reg [7:0] icr_q;
  reg [7:0] pre_q;
  reg [7:0] oac_q;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================
  // shadow of written values
  always @(posedge clock_in) begin
    if (sys_rst_in) begin
      ctl_q <= 8'h00;
      mode_q <= 8'h00;
      icr_q <= 8'h00;
      pre_q <= 8'h00;
      oac_q <= 8'h00;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        8'hF8: ctl_q <= reg_wdata_in;
        8'hF9: mode_q <= reg_wdata_in;
        8'hFA: icr_q <= reg_wdata_in;
        8'hFB: pre_q <= reg_wdata_in;
        8'hFC: oac_q <= reg_wdata_in;
        default: ;
      endcase
    end
  end
  // ==========================================================
  // assertions
  idle_rdata_a: assert property (
    !reg_rd_in |=> reg_rdata_out == 8'h00) else $error("read data not zero when idle");
  unmapped_read_a: assert property (
    reg_rd_in && (reg_addr_in < 8'hF8 || reg_addr_in > 8'hFC) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  control_readback_a: assert property (
    reg_rd_in && reg_addr_in == 8'hF8 |=> (reg_rdata_out & 8'hF8) == ($past(ctl_q) & 8'hE8))
    else $error("control readback wrong");
  mode_readback_a: assert property (
    reg_rd_in && reg_addr_in == 8'hF9 |=> reg_rdata_out == $past(mode_q))
    else $error("mode readback wrong");
  pin_ctl_readback_a: assert property (
    reg_rd_in && reg_addr_in == 8'hFA |=> reg_rdata_out == $past(icr_q))
    else $error("pin control readback wrong");
  preset_readback_a: assert property (
    reg_rd_in && reg_addr_in == 8'hFB |=> reg_rdata_out == $past(pre_q))
    else $error("preset readback wrong");
  out_forced_high_a: assert property (
    !mode_q[6] [*3] |-> first_output_pin_out) else $error("disabled output not high");
  second_pin_high_a: assert property (
    !mode_q[7] |-> second_output_pin_out) else $error("second output not high");
  parallel_follow_a: assert property (
    mode_q[2] [*3] |-> parallel_mode_out) else $error("parallel mode not shown");
  event_off_a: assert property (
    !oac_q[1] [*3] |-> !compare_event_out) else $error("event pulse while disabled");
  event_single_a: assert property (
    compare_event_out |=> !compare_event_out) else $error("event pulse too long");
  stopped_frozen_a: assert property (
    (ctl_q[7:5] == 3'b000 && icr_q == 8'h00 && !reg_wr_in) [*5] |-> $stable(count_out))
    else $error("stopped counter moved");
  cover property (compare_event_out);
  cover property (reg_rd_in && reg_addr_in == 8'hF8);
  cover property (!first_output_pin_out);
endmodule // timer_ctrl_sva

bind multifunction_timer_control timer_ctrl_sva chk_i (
  .clock_in(clock_in),
  .sys_rst_in(sys_rst_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .count_out(count_out),
  .first_output_pin_out(first_output_pin_out),
  .second_output_pin_out(second_output_pin_out),
  .compare_event_out(compare_event_out),
  .parallel_mode_out(parallel_mode_out)
);

/* bench/timer_pin_model.sv */
/*
  Model of the external input pins of the timer.
  Assumes the timer clock; levels change just after a rising edge.
*/
`timescale 1ns/1ps
module timer_pin_model (
  input wire clock_in,
  output reg pin_a_out,
  output reg pin_b_out
);
  initial begin
    pin_a_out = 1'b0;
    pin_b_out = 1'b0;
  end
  // ==========================================================
  // one edge on pin b
  task flip_b;
    begin
      @(posedge clock_in);
      pin_b_out <= ~pin_b_out;
    end
  endtask
endmodule // timer_pin_model

/* bench/testbench.sv */
/*
  Self-checking bench of the timer control block.
  Assumes a 10 MHz clock and the pin model beside the block.
*/
`timescale 1ns/1ps
module testbench;
  reg clock_in;
  reg sys_rst_in;
  reg [7:0] addr;
  reg [7:0] wdata;
  reg wr;
  reg rd;
  reg gce;
  reg [15:0] load0;
  reg [15:0] cmp0;
  wire [7:0] rdata;
  wire [15:0] count;
  wire pin_a;
  wire pin_b;
  wire out_a;
  wire evt;
  wire par;
  wire [15:0] cap0;
  wire [15:0] cap1;
  integer err_total;
  integer n_checks;
  integer i;
  reg [7:0] d;
  reg [15:0] c0;

  multifunction_timer_control uut (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr),
    .reg_wdata_in(wdata),
    .reg_wr_in(wr),
    .reg_rd_in(rd),
    .reg_rdata_out(rdata),
    .global_count_enable_in(gce),
    .first_input_pin_in(pin_a),
    .second_input_pin_in(pin_b),
    .load_value_0_in(load0),
    .load_value_1_in(16'h0000),
    .compare_value_0_in(cmp0),
    .compare_value_1_in(16'hFFFF),
    .count_out(count),
    .capture_0_out(cap0),
    .capture_1_out(cap1),
    .first_output_pin_out(out_a),
    .second_output_pin_out(),
    .compare_event_out(evt),
    .parallel_mode_out(par)
  );
  timer_pin_model pins (.clock_in(clock_in), .pin_a_out(pin_a), .pin_b_out(pin_b));

  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // ==========================================================
  // shared tasks
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clock_in);
      #1;
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] v);
    begin
      @(posedge clock_in);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock_in);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(posedge clock_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_in);
      rd <= 1'b0;
      #1;
      d = rdata;
    end
  endtask
  task give_verdict;
    begin
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // bounded wait for one event pulse, counter must stay at or below compare
  task wait_evt;
    integer k;
    begin
      k = 0;
      while (evt !== 1'b1 && k < 200) begin
        if (count > 16'h0010) chk(count, 16'h0010);
        cyc(1);
        k = k + 1;
      end
      if (k == 200) begin
        err_total = err_total + 1;
        give_verdict;
      end
    end
  endtask
  // ==========================================================
  // scenarios
  task t_reset_vals;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        rd_reg(8'hF8 + i[7:0]);
        // output control reads back the pin level, high while disabled
        chk({8'h00, d}, (i == 4) ? 16'h0001 : 16'h0000);
      end
      rd_reg(8'hF7);
      chk({8'h00, d}, 16'h0000);
      chk(count, 16'h0000);
      chk({15'h0000, out_a}, 16'h0001);
      $display("reset values done");
    end
  endtask
  task t_count;
    begin
      wr_reg(8'hFB, 8'h00);
      wr_reg(8'hF8, 8'h88);
      cyc(4);
      c0 = count;
      cyc(10);
      chk(count, c0 + 16'h000A);
      rd_reg(8'hF8);
      chk({8'h00, d}, 16'h008D);
      @(posedge clock_in);
      gce <= 1'b0;
      cyc(4);
      c0 = count;
      cyc(5);
      chk(count, c0);
      @(posedge clock_in);
      gce <= 1'b1;
      wr_reg(8'hF8, 8'h80);
      cyc(4);
      c0 = count;
      cyc(7);
      chk(count, c0 - 16'h0007);
      rd_reg(8'hF8);
      chk({8'h00, d}, 16'h0081);
      $display("count test done");
    end
  endtask
  task t_prescale;
    begin
      wr_reg(8'hFB, 8'h02);
      wr_reg(8'hF8, 8'h98);
      cyc(10);
      c0 = count;
      cyc(30);
      chk(count, c0 + 16'h000A);
      wr_reg(8'hFB, 8'h00);
      wr_reg(8'hF8, 8'h18);
      cyc(4);
      chk(count, 16'h0000);
      $display("prescale test done");
    end
  endtask
  task t_load;
    begin
      @(posedge clock_in);
      load0 <= 16'h1234;
      wr_reg(8'hF9, 8'h00);
      wr_reg(8'hFA, 8'h12);
      pins.flip_b;
      cyc(8);
      chk(count, 16'h1234);
      // capture on both registers while stopped, clear on capture
      wr_reg(8'hF9, 8'h18);
      wr_reg(8'hFA, 8'h13);
      wr_reg(8'hF8, 8'h40);
      pins.flip_b;
      cyc(8);
      chk(cap0, 16'h1234);
      chk(cap1, 16'h1234);
      chk(count, 16'h0000);
      wr_reg(8'hFA, 8'h00);
      $display("load test done");
    end
  endtask
  task t_output;
    begin
      wr_reg(8'hF9, 8'h44);
      wr_reg(8'hFC, 8'hFE);
      cyc(3);
      chk({15'h0000, out_a}, 16'h0000);
      chk({15'h0000, par}, 16'h0001);
      rd_reg(8'hFC);
      chk({8'h00, d}, 16'h00FE);
      @(posedge clock_in);
      cmp0 <= 16'h0010;
      wr_reg(8'hFC, 8'h7E);
      wr_reg(8'hF8, 8'hB8);
      cyc(3);
      wait_evt;
      cyc(2);
      chk({15'h0000, out_a}, 16'h0001);
      wait_evt;
      cyc(2);
      chk({15'h0000, out_a}, 16'h0000);
      wr_reg(8'hF9, 8'h00);
      cyc(3);
      chk({15'h0000, out_a}, 16'h0001);
      wr_reg(8'hF8, 8'h00);
      $display("output test done");
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    sys_rst_in = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    gce = 1'b1;
    load0 = 16'h0000;
    cmp0 = 16'hFFFF;
    err_total = 0;
    n_checks = 0;
    repeat (20) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    t_reset_vals;
    t_count;
    t_prescale;
    t_load;
    t_output;
    give_verdict;
  end
endmodule // testbench
